/* prr_cfg.svh */
/*
  Constants of the packet address router and configuration-port read engine.
  Assumes inclusion by the package and the design files by bare name.
*/
`ifndef PRR_CFG_SVH
`define PRR_CFG_SVH

`define PRR_CFG_PORT        8'h00
`define PRR_LAST_LINK       8'h08
`define PRR_LAST_EXT        8'h0a
`define PRR_LAST_PATH       8'h1f
`define PRR_DEF_LOG_ADDR    8'hfe
`define PRR_PROTO_ID        8'h01
`define PRR_KEY_RESET       8'h20
`define PRR_MAX_ADDR        32'h0000_0109
`define PRR_READ_LEN        24'h00_0004
`define PRR_CMD_RD_SINGLE   4'h2
`define PRR_CMD_RD_INCR     4'h3
`define PRR_CMD_RMW         4'h7
`define PRR_CMD_WR_VA       4'he
`define PRR_ST_OK           8'h00
`define PRR_ST_HDR_CRC      8'h01
`define PRR_ST_BAD_CMD      8'h02
`define PRR_ST_BAD_KEY      8'h03
`define PRR_ST_BAD_ADDR     8'h04
`define PRR_ST_BAD_LEN      8'h05
`define PRR_ST_BAD_FIELD    8'h06
`define PRR_FIFO_DEPTH      8
`define PRR_FIFO_AW         3

`endif

/* prr_pkg.sv */
/*
  Types of the packet address router and configuration-port read engine.
  Assumes prr_cfg.svh is on the include path.
*/
`include "prr_cfg.svh"

package prr_pkg;

  // One symbol of a packet stream: a data byte or an end marker.
  typedef struct packed {
    logic       eop;
    logic       eep;
    logic [7:0] data;
  } prr_sym_t;

  // Outcome of address decode for one packet.
  typedef struct packed {
    logic       to_cfg;
    logic       invalid;
    logic       strip;
    logic [3:0] port;
  } prr_route_t;

  typedef enum logic [2:0] {
    PRR_IDLE  = 3'b000,
    PRR_PASS  = 3'b001,
    PRR_SPILL = 3'b010,
    PRR_CMD   = 3'b011,
    PRR_EXEC  = 3'b100,
    PRR_REPLY = 3'b101,
    PRR_WAIT  = 3'b110
  } prr_state_t;

endpackage

/* prr_fifo.sv */
/*
  Flip-flop FIFO of packet symbols with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "prr_cfg.svh"

module prr_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = `PRR_FIFO_DEPTH,
  parameter int AW    = `PRR_FIFO_AW
)
(
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Filling side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Draining side.
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* prr_router.sv */
/*
  Packet address handling and configuration-port read-single engine.
  Incoming symbols are decoded by first byte, forwarded through a FIFO,
  spilled, or gathered as a command whose reply is streamed back out.
  Assumes the far side keeps field values it owns, a register file that
  answers a read in the same cycle as the request, and an external header
  check result that still stands in the cycle after the command's end marker.
*/
// Function
// - Path-addressed packets always lose their leading address byte.
// - Logical addresses lose the header only when the table enables it.
// - Path 11-31, invalid logical entries, empty external packets are invalid.
// - Routing back to arrival port is an error unless self routing allowed.
// - Invalid packet flags port status, spills whole packet, waits again.
// - First bytes 1 to 10 and 32 to 255 route to link or external ports.
// - First byte zero goes to the configuration port as a command.
// - Only codes 0010, 0011, 0111 and 1110 are supported; the code accepts only 0010.
// - Read single fetches one aligned 32-bit word, no increment.
// - Read address must lie from zero to 109 hex.
// - Destination logical address must be FE hex.
// - Protocol identifier is 01 hex in command and reply.
// - Key byte must match the destination key register, 20 hex at reset.
// - Zero, four, eight or twelve source path bytes head the reply.
// - Header check passes before any part of the command runs.
// - Reply leaves through the arrival port.
// - Transaction identifier is copied into the reply unchanged.
// - Reply source logical address, after the status byte, is FE hex.
// - Reply length four, then four data bytes MSB first, check, end.
// - With no source path the reply opens with source logical address.
// - First bytes 1 to 10 go straight to that physical port.
`timescale 1ns/1ps
`include "prr_cfg.svh"

module prr_router
  import prr_pkg::*;
(
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst_b,
  // Incoming packet stream and its arrival port.
  input  prr_pkg::prr_sym_t       rx_sym,
  input  wire logic               rx_valid,
  output logic                    rx_ready,
  input  wire logic [3:0]         rx_port,
  input  wire logic               rx_external,
  // Routing table lookup for logical addresses.
  output logic [7:0]              tbl_addr,
  input  wire logic [3:0]         tbl_port,
  input  wire logic               tbl_valid,
  input  wire logic               tbl_strip,
  // Configuration bits.
  input  wire logic               self_route_en,
  input  wire logic [7:0]         dest_key,
  // Header check result from the check-code unit.
  input  wire logic               hdr_check_ok,
  // Address error report to the receiving port status.
  output logic                    addr_err,
  output logic [3:0]              addr_err_port,
  // Register read port.
  output logic                    reg_rd,
  output logic [31:0]             reg_addr,
  input  wire logic [31:0]        reg_rdata,
  // Forwarded and reply stream.
  output prr_pkg::prr_sym_t       tx_sym,
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output logic [3:0]              tx_port
);

  ////////////////////////////////////////////////////////////////////////////

  localparam int HDR_MAX = 28;

  prr_state_t       state;
  prr_route_t       route;
  prr_route_t       cur;
  logic [3:0]       in_port;
  logic [7:0]       hdr [HDR_MAX];
  logic [4:0]       hcnt;
  logic [4:0]       rcnt;
  logic [4:0]       rlen;
  logic [3:0]       spl;
  logic [7:0]       status;
  logic [31:0]      rdata;
  logic [31:0]      raddr;
  logic [7:0]       cmd_byte;
  prr_sym_t         f_in;
  logic             f_in_valid;
  logic             f_in_ready;
  prr_sym_t         f_out;
  logic             f_out_valid;
  logic             take;
  logic             head_bad;

  // Decode of a first byte into destination, invalid and strip flags.
  function automatic prr_route_t decode(input logic [7:0] a, input logic [3:0] tp,
                                        input logic tv, input logic ts);
    prr_route_t r;
    r = '0;
    r.to_cfg = (a == `PRR_CFG_PORT);
    if (a <= `PRR_LAST_PATH)
    begin
      r.port = a[3:0];
      r.strip = 1'b1;
      r.invalid = (a > `PRR_LAST_EXT);
    end
    else
    begin
      r.port = tp;
      r.strip = ts;
      r.invalid = !tv;
    end
    return r;
  endfunction

  assign tbl_addr = rx_sym.data;
  assign route    = decode(rx_sym.data, tbl_port, tbl_valid, tbl_strip);
  assign take     = rx_valid && rx_ready;
  assign head_bad = route.invalid || (!route.to_cfg && route.port == rx_port && !self_route_en);
  assign cmd_byte = {2'b00, hdr[2][5:0]};
  // Source path bytes counted from the two length bits.
  assign spl      = {hdr[2][1:0], 2'b00};
  assign raddr    = {hdr[spl+8], hdr[spl+9], hdr[spl+10], hdr[spl+11]};

  always_comb
  begin
    rx_ready = 1'b0;
    unique case (state)
      PRR_IDLE:  rx_ready = !f_out_valid;
      PRR_PASS:  rx_ready = f_in_ready;
      PRR_SPILL: rx_ready = 1'b1;
      PRR_CMD:   rx_ready = 1'b1;
      PRR_EXEC:  rx_ready = 1'b0;
      PRR_REPLY: rx_ready = 1'b0;
      PRR_WAIT:  rx_ready = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet state.

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= PRR_IDLE;
      cur      <= '0;
      in_port  <= '0;
      hcnt     <= '0;
      addr_err <= 1'b0;
      addr_err_port <= '0;
    end
    else
    begin
      addr_err <= 1'b0;
      unique case (state)
        PRR_IDLE:
        begin
          if (take)
          begin
            cur     <= route;
            in_port <= rx_port;
            hcnt    <= '0;
            if (rx_sym.eop || rx_sym.eep)
            begin
              addr_err      <= rx_external;
              addr_err_port <= rx_port;
            end
            else if (head_bad)
            begin
              addr_err      <= 1'b1;
              addr_err_port <= rx_port;
              state         <= PRR_SPILL;
            end
            else if (route.to_cfg)
            begin
              state <= PRR_CMD;
            end
            else
            begin
              state <= PRR_PASS;
            end
          end
        end
        PRR_PASS, PRR_SPILL:
        begin
          if (take && (rx_sym.eop || rx_sym.eep))
          begin
            state <= PRR_IDLE;
          end
        end
        PRR_CMD:
        begin
          if (take)
          begin
            if (rx_sym.eop || rx_sym.eep)
            begin
              state <= PRR_EXEC;
            end
            else if (hcnt != 5'(HDR_MAX))
            begin
              hcnt <= hcnt + 1'b1;
            end
          end
        end
        PRR_EXEC:
        begin
          state <= PRR_WAIT;
        end
        PRR_WAIT:
        begin
          state <= PRR_REPLY;
        end
        PRR_REPLY:
        begin
          if (tx_ready && rcnt == rlen)
          begin
            state <= PRR_IDLE;
          end
        end
      endcase
    end
  end

  // Command header capture.
  always_ff @(posedge clock)
  begin
    if (state == PRR_CMD && take && !rx_sym.eop && !rx_sym.eep && hcnt < 5'(HDR_MAX))
    begin
      hdr[hcnt] <= rx_sym.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command checks and register read.

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status   <= `PRR_ST_OK;
      reg_rd   <= 1'b0;
      reg_addr <= '0;
      rdata    <= '0;
    end
    else
    begin
      reg_rd <= 1'b0;
      if (state == PRR_EXEC)
      begin
        reg_addr <= raddr;
        if (!hdr_check_ok || hcnt != 5'(spl + 16))
        begin
          status <= `PRR_ST_HDR_CRC;
        end
        else if (hdr[0] != `PRR_DEF_LOG_ADDR || hdr[1] != `PRR_PROTO_ID)
        begin
          status <= `PRR_ST_BAD_FIELD;
        end
        else if (hdr[3] != dest_key)
        begin
          status <= `PRR_ST_BAD_KEY;
        end
        else if (hdr[2][5:2] != `PRR_CMD_RD_SINGLE)
        begin
          status <= `PRR_ST_BAD_CMD;
        end
        else if (raddr[1:0] != 2'b00 || raddr > `PRR_MAX_ADDR)
        begin
          status <= `PRR_ST_BAD_ADDR;
        end
        else if ({hdr[spl+12], hdr[spl+13], hdr[spl+14]} != `PRR_READ_LEN)
        begin
          status <= `PRR_ST_BAD_LEN;
        end
        else
        begin
          status <= `PRR_ST_OK;
          reg_rd <= 1'b1;
        end
      end
      if (state == PRR_WAIT)
      begin
        rdata <= (status == `PRR_ST_OK) ? reg_rdata : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply and forwarding output.

  function automatic logic [7:0] reply_byte(input logic [4:0] i);
    logic [4:0] j;
    j = i - spl;
    if (i < spl)
    begin
      return hdr[5'd4 + i];
    end
    unique case (j)
      5'd0:  return hdr[spl+4];
      5'd1:  return `PRR_PROTO_ID;
      5'd2:  return cmd_byte;
      5'd3:  return status;
      5'd4:  return `PRR_DEF_LOG_ADDR;
      5'd5:  return hdr[spl+5];
      5'd6:  return hdr[spl+6];
      5'd7:  return 8'h00;
      5'd8:  return 8'(`PRR_READ_LEN >> 16);
      5'd9:  return 8'(`PRR_READ_LEN >> 8);
      5'd10: return 8'(`PRR_READ_LEN);
      5'd11: return 8'h00;
      5'd12: return rdata[31:24];
      5'd13: return rdata[23:16];
      5'd14: return rdata[15:8];
      5'd15: return rdata[7:0];
      default: return 8'h00;
    endcase
  endfunction

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rcnt <= '0;
      rlen <= '0;
    end
    else if (state == PRR_WAIT)
    begin
      rcnt <= '0;
      rlen <= 5'(spl + 17);
    end
    else if (state == PRR_REPLY && tx_ready)
    begin
      rcnt <= rcnt + 1'b1;
    end
  end

  assign f_in       = rx_sym;
  assign f_in_valid = (state == PRR_PASS) ? rx_valid : (state == PRR_IDLE) && take && !head_bad
                      && !route.to_cfg && !route.strip && !rx_sym.eop && !rx_sym.eep;

  prr_fifo #(.WIDTH(10), .DEPTH(`PRR_FIFO_DEPTH), .AW(`PRR_FIFO_AW)) u_fifo
  (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_data   (f_in),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (tx_ready && state != PRR_REPLY)
  );

  always_comb
  begin
    tx_sym   = f_out;
    tx_valid = f_out_valid && state != PRR_REPLY;
    tx_port  = cur.port;
    if (state == PRR_REPLY)
    begin
      tx_port      = in_port;
      tx_valid     = 1'b1;
      tx_sym.data  = reply_byte(rcnt);
      tx_sym.eop   = (rcnt == rlen);
      tx_sym.eep   = 1'b0;
    end
  end

endmodule

/* prr_router_properties.sv */
/*
  Port assertions for the packet address router.
  Assumes a bind onto prr_router from the testbench.
*/
`timescale 1ns/1ps
`include "prr_cfg.svh"

module prr_router_properties
  import prr_pkg::*;
(
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst_b,
  // Watched ports.
  input  prr_pkg::prr_sym_t rx_sym,
  input  wire logic         rx_valid,
  input  wire logic         rx_ready,
  input  wire logic [3:0]   rx_port,
  input  wire logic         self_route_en,
  input  wire logic         addr_err,
  input  wire logic [3:0]   addr_err_port,
  input  wire logic         reg_rd,
  input  wire logic [31:0]  reg_addr,
  input  prr_pkg::prr_sym_t tx_sym,
  input  wire logic         tx_valid,
  input  wire logic         tx_ready,
  input  wire logic [3:0]   tx_port
);
  logic first;
  logic head;

  // Marks the symbol that opens a packet.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      first <= 1'b1;
    else if (rx_valid && rx_ready)
      first <= rx_sym.eop || rx_sym.eep;
  end
  assign head = first && rx_valid && rx_ready && !rx_sym.eop && !rx_sym.eep;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  err_pulse_a:
    assert property (addr_err |=> !addr_err) else $error("addr_err too long");
  err_port_a:
    assert property (addr_err |-> addr_err_port == $past(rx_port))
      else $error("addr_err_port wrong");
  bad_path_a:
    assert property (head && rx_sym.data inside {[8'h0b:8'h1f]} |=> addr_err)
      else $error("invalid path not flagged");
  loop_err_a:
    assert property (head && rx_sym.data inside {[8'h01:8'h0a]} && rx_sym.data[3:0] == rx_port
                     && !self_route_en |=> addr_err) else $error("loop-back not flagged");
  path_ok_a:
    assert property (head && rx_sym.data <= 8'h0a && rx_sym.data[3:0] != rx_port |=> !addr_err)
      else $error("valid path flagged");
  rd_once_a:
    assert property (reg_rd |=> !reg_rd) else $error("second register read");
  rd_range_a:
    assert property (reg_rd |-> reg_addr[1:0] == 2'b00 && reg_addr <= `PRR_MAX_ADDR)
      else $error("read address out of range");
  rx_hold_a:
    assert property (reg_rd |-> !rx_ready) else $error("input open during read");
  reply_soon_a:
    assert property (reg_rd |-> ##[1:3] tx_valid) else $error("reply late");
  tx_stand_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_sym) && $stable(tx_port))
      else $error("tx symbol dropped");

  cover property (reg_rd);
  cover property (addr_err);
  cover property (tx_valid && tx_ready && tx_sym.eop);
endmodule

/* prr_far_model.sv */
/*
  Far-side model: routing table and register file.
  Assumes the router's lookup and read ports.
*/
`timescale 1ns/1ps

module prr_far_model
(
  // Clock.
  input  wire logic        clock,
  // Table lookup.
  input  wire logic [7:0]  tbl_addr,
  output logic [3:0]       tbl_port,
  output logic             tbl_valid,
  output logic             tbl_strip,
  // Register read.
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  output logic [31:0]      reg_rdata
);
  assign tbl_valid = tbl_addr != 8'h50;
  assign tbl_port  = 4'(tbl_addr % 8'd10) + 4'h1;
  assign tbl_strip = tbl_addr[0];

  // Read data is valid only while the read strobe stands; it toggles otherwise.
  logic [31:0] noise = 32'h0;
  always @(posedge clock)
    noise <= ~noise;
  assign reg_rdata = reg_rd ? {reg_addr[7:0], ~reg_addr[7:0], 8'h3c, reg_addr[7:0] ^ 8'ha5}
                            : noise;
endmodule

/* prr_router_tb.sv */
/*
  Self-checking testbench of the packet address router.
  Assumes the design, the far-side model and the checker.
*/
`timescale 1ns/1ps
`include "prr_cfg.svh"

module prr_router_tb;
  import prr_pkg::*;
  typedef struct packed
  {
    logic       skip;
    logic [3:0] port;
    prr_sym_t   sym;
  } prr_note_t;

  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  prr_sym_t    rx_sym = '0, tx_sym;
  logic        rx_valid = 1'b0, rx_ready, rx_external = 1'b0, tx_valid, tx_ready = 1'b1;
  logic [3:0]  rx_port = 4'h3, tbl_port, addr_err_port, tx_port;
  logic [7:0]  tbl_addr, dest_key = 8'h20;
  logic        tbl_valid, tbl_strip, self_route_en = 1'b0, hdr_check_ok = 1'b1;
  logic        addr_err, reg_rd, stall = 1'b0, full_seen = 1'b0;
  logic [7:0]  cmd_len = 8'h04, cmd_dla = 8'hfe;
  logic [31:0] reg_addr, reg_rdata;
  int          n_fail = 0, checks_done = 0, errs_seen = 0, rds_seen = 0, errs_before = 0;
  prr_note_t   notes[$];

  always #5 clock = ~clock;
  always @(posedge clock)
    tx_ready <= !stall && ($urandom % 4 != 0);

  prr_router dut_u (.clock, .rst_b, .rx_sym, .rx_valid, .rx_ready, .rx_port, .rx_external,
    .tbl_addr, .tbl_port, .tbl_valid, .tbl_strip, .self_route_en, .dest_key, .hdr_check_ok,
    .addr_err, .addr_err_port, .reg_rd, .reg_addr, .reg_rdata, .tx_sym, .tx_valid,
    .tx_ready, .tx_port);
  prr_far_model far_u (.clock, .tbl_addr, .tbl_port, .tbl_valid, .tbl_strip, .reg_rd,
    .reg_addr, .reg_rdata);

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock)
    if (rst_b)
    begin
      if (addr_err === 1'b1)
        errs_seen++;
      if (addr_err === 1'b1)
        check("addr_err_port", 32'(addr_err_port), 32'(rx_port));
      if (reg_rd === 1'b1)
        rds_seen++;
      if (tx_valid === 1'b1 && tx_ready)
      begin
        if (notes.size() == 0)
          check("tx extra", 32'(tx_sym), 32'hffff_ffff);
        else if (!notes[0].skip)
        begin
          check("tx_sym", 32'(tx_sym), 32'(notes[0].sym));
          check("tx_port", 32'(tx_port), 32'(notes[0].port));
          void'(notes.pop_front());
        end
        else if (tx_sym.eop || tx_sym.eep)
          void'(notes.pop_front());
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [9:0] s);
    logic r;
    rx_sym <= s;
    rx_valid <= 1'b1;
    r = 1'b0;
    for (int n = 0; n < 300 && !r; n++)
    begin
      @(negedge clock);
      r = rx_ready;
      full_seen |= !r;
      @(posedge clock);
    end
    if (!r)
    begin
      n_fail++;
      conclude();
    end
  endtask

  task automatic pkt(input logic [7:0] b[$]);
    foreach (b[i])
      put({2'b00, b[i]});
    put(10'h200);
    rx_valid <= 1'b0;
    for (int n = 0; n < 400 && notes.size() > 0; n++)
      @(posedge clock);
    if (notes.size() > 0)
    begin
      n_fail++;
      conclude();
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic note(input logic [7:0] v);
    notes.push_back({1'b0, rx_port, 2'b00, v});
  endtask

  task automatic data_pkt(input logic [7:0] a, input int n, input logic [3:0] dst,
                          input logic bad);
    logic [7:0] b[$];
    int         e;
    e = errs_seen;
    b.push_back(a);
    for (int i = 0; i < n; i++)
      b.push_back(8'($urandom));
    // header stays when the table keeps it
    if (!bad && a > 8'h1f && !a[0])
      notes.push_back({1'b0, dst, 2'b00, a});
    for (int i = 1; i <= n && !bad; i++)
      notes.push_back({1'b0, dst, 2'b00, b[i]});
    if (!bad)
      notes.push_back({1'b0, dst, 10'h200});
    pkt(b);
    check("addr_err count", 32'(errs_seen - e), 32'(bad));
  endtask

  task automatic cmd(input logic [3:0] code, input int np, input logic [7:0] key,
                     input logic [31:0] adr, input logic hok, input logic [7:0] st);
    logic [7:0]  b[$];
    logic [7:0]  c, sla;
    logic [15:0] tid;
    logic [31:0] d;
    int          r;
    tid = 16'($urandom);
    sla = 8'($urandom);
    c = {2'b01, code, 2'(np / 4)};
    d = {adr[7:0], ~adr[7:0], 8'h3c, adr[7:0] ^ 8'ha5};
    r = rds_seen;
    hdr_check_ok <= hok;
    b = {8'h00, cmd_dla, 8'h01, c, key};
    for (int i = 0; i < np; i++)
      b.push_back(8'h40 + 8'(i));
    b = {b, sla, tid[15:8], tid[7:0], 8'h00, adr[31:24], adr[23:16], adr[15:8], adr[7:0],
         8'h00, 8'h00, cmd_len, 8'h00};
    for (int i = 0; i < np; i++)
      note(8'h40 + 8'(i));
    b.push_back(8'h00);
    void'(b.pop_back());
    note(sla);
    note(8'h01);
    note(c & 8'h3f);
    note(st);
    if (st != 8'h00)
      notes.push_back({1'b1, 4'h0, 10'h0});
    else
      foreach (b[i])
        if (i < 8)
          note({8'hfe, tid, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00}[63 - 8 * i -: 8]);
        else if (i < 12)
          note(d[31 - 8 * (i - 8) -: 8]);
    // data check byte, then end marker
    if (st == 8'h00)
    begin
      note(8'h00);
      notes.push_back({1'b0, rx_port, 10'h200});
    end
    pkt(b);
    check("register reads", 32'(rds_seen - r), 32'(st == 8'h00));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h1f19));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    data_pkt(8'h05, 6, 4'h5, 1'b0);
    data_pkt(8'h0a, 1, 4'ha, 1'b0);
    stall <= 1'b1;
    full_seen = 1'b0;
    fork
      begin
        repeat (40) @(posedge clock);
        stall <= 1'b0;
      end
    join_none
    data_pkt(8'h01, 14, 4'h1, 1'b0);
    check("fifo refused", 32'(full_seen), 32'h1);
    data_pkt(8'h0b, 2, 4'h0, 1'b1);
    data_pkt(8'h1f, 2, 4'h0, 1'b1);
    data_pkt(8'h03, 2, 4'h0, 1'b1);
    self_route_en <= 1'b1;
    data_pkt(8'h03, 2, 4'h3, 1'b0);
    data_pkt(8'h28, 3, 4'h1, 1'b0);
    data_pkt(8'h29, 2, 4'h2, 1'b0);
    data_pkt(8'h50, 2, 4'h0, 1'b1);
    rx_external <= 1'b1;
    errs_before = errs_seen;
    pkt('{});
    check("empty external", 32'(errs_seen - errs_before), 32'h1);
    rx_external <= 1'b0;
    errs_before = errs_seen;
    pkt('{});
    check("empty internal", 32'(errs_seen - errs_before), 32'h0);
    cmd(4'h2, 0, 8'h20, 32'h0000_0108, 1'b1, 8'h00);
    cmd(4'h2, 4, 8'h20, {22'h0, 8'($urandom % 67), 2'b00}, 1'b1, 8'h00);
    cmd(4'h2, 12, 8'h20, 32'h0, 1'b1, 8'h00);
    cmd(4'h2, 8, 8'h21, 32'h4, 1'b1, 8'h03);
    cmd(4'h2, 0, 8'h20, 32'h4, 1'b0, 8'h01);
    cmd(4'h2, 0, 8'h20, 32'h0000_0102, 1'b1, 8'h04);
    cmd(4'h2, 0, 8'h20, 32'h0000_010c, 1'b1, 8'h04);
    cmd_len = 8'h08;
    cmd(4'h2, 0, 8'h20, 32'h8, 1'b1, 8'h05);
    cmd_len = 8'h04;
    cmd_dla = 8'hfd;
    cmd(4'h2, 0, 8'h20, 32'h8, 1'b1, 8'h06);
    cmd_dla = 8'hfe;
    for (int k = 0; k < 16; k++)
      if (k != 2)
        cmd(4'(k), 0, 8'h20, 32'h8, 1'b1, 8'h02);
    dest_key <= 8'h5a;
    cmd(4'h2, 0, 8'h5a, 32'h10, 1'b1, 8'h00);
    conclude();
  end
endmodule

bind prr_router prr_router_properties chk_u (.clock, .rst_b, .rx_sym, .rx_valid, .rx_ready,
  .rx_port, .self_route_en, .addr_err, .addr_err_port, .reg_rd, .reg_addr, .tx_sym,
  .tx_valid, .tx_ready, .tx_port);
